// ==== hdl/asp_defines.svh ====
`ifndef ASP_DEFINES_SVH
`define ASP_DEFINES_SVH
// Behaviour
// - Non-PASID requests skip stage 1 under full ATS, substreams on, bypass encoding.
// - With stage 2 on, such requests translate stage 2 only, returning the PA.
// - Attribute is fixed input plus overrides, combined with the stage 2 attribute.
// - Stage 2 off: identity completion, U clear, R and W set, same address.
// - Identity size covers the address and never exceeds the output address size.
// - Skip completions report execute and privileged access both zero.
// - Identity attribute is fixed input plus overrides, encoded into the address.
// - Split-stage skip needs both stages, split ATS, substreams on, bypass encoding.
// - Split skip may fault when the address exceeds the input address size.
// - Split skip completion: U clear, stage 2 R and W, intermediate address returned.
// - Split skip translation size never exceeds the stage 2 size.
// - Split skip attribute is fixed input plus overrides alone, not combined with stage 2.
// - Later translated accesses under split ATS go through stage 2 only.
// - Ordinary transactions use read/write and PASID privilege directly.
// - Ordinary transactions without PASID are data accesses at unprivileged level.
// - NW clear on a writable or dirty page grants write.
// - NW set on a writable page may grant write.
// - Without flag update, a page lacking write never gets write granted.
// - With flag update, NW clear to writable-clean marks dirty, then grants write.
// - Flag update never marks a page dirty for an NW set request.
// - Execute needs the request flag and page execute; execute implies read.
// - Execute request to execute-only page gets nothing unless instruction override.
// - Completion privilege equals request privilege.
`define ASP_REG_CFG    12'h000
`define ASP_REG_ASZ    12'h004
`define ASP_REG_STAT   12'h008
`define ASP_F_S1       0
`define ASP_F_S2       1
`define ASP_F_STG      1:0
`define ASP_F_MODE     3:2
`define ASP_F_SUBS     8:4
`define ASP_F_NPS      10:9
`define ASP_F_INST     11
`define ASP_F_FLUPD    12
`define ASP_F_ATTEN    13
`define ASP_F_OVEN     14
`define ASP_F_OVATTR   23:16
`define ASP_F_INSZ     5:0
`define ASP_F_OUTSZ    13:8
`define ASP_F_BUSY     0
`define ASP_F_FLT      1
`define ASP_F_KIND     3:2
`define ASP_F_RSVD     15:4
`define ASP_F_CNT      31:16
`define ASP_CFG_RST    32'h0000_0000
`define ASP_ASZ_RST    32'h0000_3030
`define ASP_MODE_FULL  2'h1
`define ASP_MODE_SPLIT 2'h2
`define ASP_STG_BOTH   2'h3
`define ASP_NPS_BYPASS 2'h1
`define ASP_FIXED_ATTR 8'hFF
`define ASP_ADDR_W     64
`define ASP_PA_MSB     55
`define ASP_ATTR_F     63:56
`define ASP_SZ_W       6
`define ASP_CNT_MAX    16
`endif

// ==== hdl/asp_pkg.sv ====
package asp_pkg;
`include "asp_defines.svh"
	typedef enum logic [1:0] {st_idle, st_walk, st_dirty, st_resp} asp_state_e;
	typedef enum logic [1:0] {k_none, k_ident, k_full2, k_split} asp_kind_e;
	typedef logic [`ASP_ADDR_W-1:0] asp_addr_t;
	typedef logic [7:0]             asp_attr_t;
	typedef logic [`ASP_SZ_W-1:0]   asp_size_t;

	// Lower code is the weaker attribute and wins the combination.
	function automatic asp_attr_t asp_attr_comb(input asp_attr_t a, input asp_attr_t b);
		return (a < b) ? a : b;
	endfunction
endpackage

// ==== hdl/asp_perm_if.sv ====
`timescale 1ns/1ps
interface asp_perm_if;
	logic nw;
	logic exe;
	logic inst_ovr;
	logic flag_upd;
	logic pg_r;
	logic pg_w;
	logic pg_x;
	logic pg_dmod;
	logic gr_r;
	logic gr_w;
	logic gr_x;
	logic mk_dirty;
	modport core (output nw, exe, inst_ovr, flag_upd, pg_r, pg_w, pg_x, pg_dmod,
		input gr_r, gr_w, gr_x, mk_dirty);
	modport perm (input nw, exe, inst_ovr, flag_upd, pg_r, pg_w, pg_x, pg_dmod,
		output gr_r, gr_w, gr_x, mk_dirty);
endinterface

// ==== hdl/asp_perm.sv ====
`timescale 1ns/1ps
module asp_perm
(
	asp_perm_if.perm pif
);
	logic x_ok;
	logic runonly_block;
	logic clean;

	assign x_ok = pif.exe && pif.pg_x;
	// Execute-only page refuses an execute request unless fetches are forced.
	assign runonly_block = x_ok && !pif.pg_r && !pif.inst_ovr;
	// Writable-clean page, only promoted for a request that intends to write.
	assign clean = pif.flag_upd && pif.pg_dmod && !pif.pg_w && !pif.nw;
	assign pif.mk_dirty = clean && !runonly_block;
	// Write is granted on a writable page whatever NW says, unless the execute-only block refuses the request.
	assign pif.gr_w = !runonly_block && (pif.pg_w || clean);
	assign pif.gr_r = !runonly_block && (pif.pg_r || x_ok);
	assign pif.gr_x = !runonly_block && x_ok;
endmodule

// ==== hdl/asp_skip_top.sv ====
`timescale 1ns/1ps
`include "asp_defines.svh"
module asp_skip_top
#(
	parameter int CNT_W = 16
)
(
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic [31:0]            hrdata,
	input  wire logic              tr_valid,
	output logic                   tr_ready,
	input  wire asp_pkg::asp_addr_t tr_addr,
	input  wire logic              tr_pasid_present,
	input  wire logic              tr_nw,
	input  wire logic              tr_exe,
	input  wire logic              tr_priv,
	output logic                   s2_req_valid,
	output asp_pkg::asp_addr_t     s2_req_addr,
	input  wire logic              s2_rsp_valid,
	input  wire asp_pkg::asp_addr_t s2_rsp_pa,
	input  wire asp_pkg::asp_size_t s2_rsp_size,
	input  wire logic              s2_rsp_r,
	input  wire logic              s2_rsp_w,
	input  wire logic              s2_rsp_x,
	input  wire logic              s2_rsp_dmod,
	input  wire logic              s2_rsp_fault,
	input  wire asp_pkg::asp_attr_t s2_rsp_attr,
	output logic                   dirty_req_valid,
	output asp_pkg::asp_addr_t     dirty_req_addr,
	input  wire logic              dirty_ack,
	output logic                   cpl_valid,
	input  wire logic              cpl_ready,
	output logic                   cpl_handled,
	output asp_pkg::asp_addr_t     cpl_addr,
	output asp_pkg::asp_size_t     cpl_size,
	output logic                   cpl_u,
	output logic                   cpl_r,
	output logic                   cpl_w,
	output logic                   cpl_x,
	output logic                   cpl_priv,
	input  wire logic              tx_valid,
	input  wire logic              tx_pasid_present,
	input  wire logic              tx_write,
	input  wire logic              tx_exe,
	input  wire logic              tx_priv,
	output logic                   tx_attr_valid,
	output logic                   tx_attr_write,
	output logic                   tx_attr_inst,
	output logic                   tx_attr_priv,
	output logic                   xlat_s2_only
);
	import asp_pkg::*;

	typedef struct packed {
		asp_state_e       st;
		asp_kind_e        kind;
		logic [31:0]      cfg;
		logic [31:0]      asz;
		logic             ph_wr;
		logic [11:0]      ph_addr;
		logic [31:0]      rdata;
		asp_addr_t        req_addr;
		logic             req_nw;
		logic             req_exe;
		logic             req_priv;
		asp_attr_t        req_attr;
		asp_addr_t        c_addr;
		asp_size_t        c_size;
		logic             c_hnd;
		logic             c_r;
		logic             c_w;
		logic             c_x;
		logic             c_flt;
		logic [CNT_W-1:0] cnt;
		logic             tx_v;
		logic             tx_w;
		logic             tx_i;
		logic             tx_p;
		logic             s2only;
	} asp_st_s;

	asp_st_s    cur;
	asp_st_s    next_cur;
	asp_perm_if pif ();
	logic       subs_on;
	logic       bypass;
	logic       full_skip;
	logic       split_skip;
	logic       over_insz;
	logic       over_outsz;
	asp_attr_t  in_attr;
	logic [31:0] stat_w;

	if (CNT_W < 1 || CNT_W > `ASP_CNT_MAX)
	begin
		$error("CNT_W must lie between 1 and 16.");
	end

	function automatic asp_addr_t asp_enc(input asp_addr_t a, input asp_attr_t t,
		input logic en);
		asp_addr_t r;
		r = a;
		if (en)
		begin
			r[`ASP_ATTR_F] = t;
		end
		return r;
	endfunction

	asp_perm u_perm
	(
		.pif (pif)
	);

	assign pif.nw = cur.req_nw;
	assign pif.exe = cur.req_exe;
	assign pif.inst_ovr = cur.cfg[`ASP_F_INST];
	assign pif.flag_upd = cur.cfg[`ASP_F_FLUPD];
	assign pif.pg_r = s2_rsp_r;
	assign pif.pg_w = s2_rsp_w;
	assign pif.pg_x = s2_rsp_x;
	assign pif.pg_dmod = s2_rsp_dmod;

	// Skip decisions look at the entry fields live in the arrival cycle.
	assign subs_on = cur.cfg[`ASP_F_SUBS] != '0;
	assign bypass = subs_on && cur.cfg[`ASP_F_NPS] == `ASP_NPS_BYPASS
		&& !tr_pasid_present;
	assign full_skip = bypass && cur.cfg[`ASP_F_S1]
		&& cur.cfg[`ASP_F_MODE] == `ASP_MODE_FULL;
	assign split_skip = bypass && cur.cfg[`ASP_F_STG] == `ASP_STG_BOTH
		&& cur.cfg[`ASP_F_MODE] == `ASP_MODE_SPLIT;
	assign over_insz = (tr_addr >> cur.asz[`ASP_F_INSZ]) != '0;
	assign over_outsz = (tr_addr >> cur.asz[`ASP_F_OUTSZ]) != '0;
	assign in_attr = cur.cfg[`ASP_F_OVEN] ? cur.cfg[`ASP_F_OVATTR] : `ASP_FIXED_ATTR;

	assign stat_w[`ASP_F_BUSY] = cur.st != st_idle;
	assign stat_w[`ASP_F_FLT] = cur.c_flt;
	assign stat_w[`ASP_F_KIND] = cur.kind;
	assign stat_w[`ASP_F_RSVD] = '0;
	assign stat_w[`ASP_F_CNT] = 16'(cur.cnt);

	always_comb
	begin
		next_cur = cur;
		if (cur.ph_wr && cur.ph_addr == `ASP_REG_CFG)
		begin
			next_cur.cfg = hwdata;
		end
		if (cur.ph_wr && cur.ph_addr == `ASP_REG_ASZ)
		begin
			next_cur.asz = hwdata;
		end
		next_cur.ph_wr = 1'b0;
		if (hsel && hready && htrans[1])
		begin
			next_cur.ph_wr = hwrite;
			next_cur.ph_addr = haddr[11:0];
			next_cur.rdata = '0;
			if (!hwrite && haddr[11:0] == `ASP_REG_CFG)
			begin
				next_cur.rdata = next_cur.cfg;
			end
			if (!hwrite && haddr[11:0] == `ASP_REG_ASZ)
			begin
				next_cur.rdata = next_cur.asz;
			end
			if (!hwrite && haddr[11:0] == `ASP_REG_STAT)
			begin
				next_cur.rdata = stat_w;
			end
		end
		// Ordinary traffic attributes; no prefix means data, unprivileged.
		next_cur.tx_v = tx_valid;
		next_cur.tx_w = tx_write;
		next_cur.tx_i = tx_pasid_present && tx_exe && !tx_write;
		next_cur.tx_p = tx_pasid_present && tx_priv;
		next_cur.s2only = cur.cfg[`ASP_F_STG] == `ASP_STG_BOTH
			&& cur.cfg[`ASP_F_MODE] == `ASP_MODE_SPLIT;
		unique case (cur.st)
			st_idle:
			begin
				if (tr_valid)
				begin
					next_cur.req_addr = tr_addr;
					next_cur.req_nw = tr_nw;
					next_cur.req_exe = tr_pasid_present && tr_exe;
					next_cur.req_priv = tr_pasid_present && tr_priv;
					next_cur.req_attr = in_attr;
					next_cur.c_hnd = full_skip || split_skip;
					next_cur.c_addr = tr_addr;
					next_cur.c_size = '0;
					next_cur.c_r = 1'b0;
					next_cur.c_w = 1'b0;
					next_cur.c_x = 1'b0;
					next_cur.c_flt = 1'b0;
					next_cur.st = st_resp;
					if (!(full_skip || split_skip))
					begin
						next_cur.kind = k_none;
					end
					else if (split_skip && over_insz)
					begin
						next_cur.kind = k_split;
						next_cur.c_flt = 1'b1;
					end
					else if (full_skip && !cur.cfg[`ASP_F_S2])
					begin
						next_cur.kind = k_ident;
						if (over_outsz)
						begin
							next_cur.c_flt = 1'b1;
						end
						else
						begin
							next_cur.c_r = 1'b1;
							next_cur.c_w = 1'b1;
							next_cur.c_addr = asp_enc(tr_addr, in_attr,
								cur.cfg[`ASP_F_ATTEN]);
							next_cur.c_size = cur.asz[`ASP_F_OUTSZ];
						end
					end
					else
					begin
						next_cur.kind = split_skip ? k_split : k_full2;
						next_cur.st = st_walk;
					end
				end
			end
			st_walk:
			begin
				if (s2_rsp_valid && s2_rsp_fault)
				begin
					next_cur.c_flt = 1'b1;
					next_cur.st = st_resp;
				end
				else if (s2_rsp_valid)
				begin
					next_cur.c_r = pif.gr_r;
					next_cur.c_w = pif.gr_w;
					next_cur.c_x = pif.gr_x;
					next_cur.c_size = s2_rsp_size;
					if (cur.kind == k_split)
					begin
						next_cur.c_addr = asp_enc(cur.req_addr, cur.req_attr,
							cur.cfg[`ASP_F_ATTEN]);
					end
					else
					begin
						next_cur.c_addr = asp_enc(s2_rsp_pa,
							asp_attr_comb(cur.req_attr, s2_rsp_attr),
							cur.cfg[`ASP_F_ATTEN]);
					end
					next_cur.st = pif.mk_dirty ? st_dirty : st_resp;
				end
			end
			st_dirty:
			begin
				if (dirty_ack)
				begin
					next_cur.st = st_resp;
				end
			end
			st_resp:
			begin
				if (cpl_ready)
				begin
					next_cur.st = st_idle;
					next_cur.cnt = cur.cnt + 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cur <= '0;
			cur.st <= st_idle;
			cur.kind <= k_none;
			cur.cfg <= `ASP_CFG_RST;
			cur.asz <= `ASP_ASZ_RST;
		end
		else
		begin
			cur <= next_cur;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = cur.rdata;
	assign tr_ready = cur.st == st_idle;
	assign s2_req_valid = cur.st == st_walk;
	assign s2_req_addr = cur.req_addr;
	assign dirty_req_valid = cur.st == st_dirty;
	assign dirty_req_addr = cur.req_addr;
	assign cpl_valid = cur.st == st_resp;
	assign cpl_handled = cur.c_hnd;
	assign cpl_addr = cur.c_addr;
	assign cpl_size = cur.c_size;
	assign cpl_u = 1'b0;
	assign cpl_r = cur.c_r;
	assign cpl_w = cur.c_w;
	assign cpl_x = cur.c_x;
	assign cpl_priv = cur.req_priv;
	assign tx_attr_valid = cur.tx_v;
	assign tx_attr_write = cur.tx_w;
	assign tx_attr_inst = cur.tx_i;
	assign tx_attr_priv = cur.tx_p;
	assign xlat_s2_only = cur.s2only;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence s_dirty_done;
		dirty_req_valid && dirty_ack;
	endsequence
	sequence s_cpl_write;
		cpl_valid && cpl_w;
	endsequence
	sequence s_take_big;
		tr_valid && tr_ready && split_skip && over_insz;
	endsequence
	sequence s_walk_ok;
		cur.st == st_walk && s2_rsp_valid && !s2_rsp_fault;
	endsequence

	a_dirty_then_w: assert property (s_dirty_done |=> s_cpl_write)
		else $error("Dirty update not followed by a write grant.");
	a_ident_perm: assert property (cpl_valid && cur.kind == k_ident && !cur.c_flt
		|-> cpl_r && cpl_w && !cpl_u && cpl_size == cur.asz[`ASP_F_OUTSZ])
		else $error("Identity completion has wrong permissions or size.");
	a_ident_addr: assert property (cpl_valid && cur.kind == k_ident && !cur.c_flt
		|-> cpl_addr[`ASP_PA_MSB:0] == cur.req_addr[`ASP_PA_MSB:0])
		else $error("Identity completion address differs from request.");
	a_attr_encode: assert property (cpl_valid && cur.kind == k_ident && !cur.c_flt
		&& cur.cfg[`ASP_F_ATTEN] |-> cpl_addr[`ASP_ATTR_F] == cur.req_attr)
		else $error("Identity attribute not encoded in address.");
	a_no_exec_priv: assert property (cpl_valid && cpl_handled
		|-> !cpl_x && !cpl_priv)
		else $error("Skip completion grants execute or privilege.");
	a_exec_read: assert property (cpl_valid && cpl_x |-> cpl_r)
		else $error("Execute granted without read.");
	a_nw_clean: assert property (dirty_req_valid |-> !cur.req_nw)
		else $error("Dirty marking for a no-write request.");
	a_split_addr: assert property (cpl_valid && cur.kind == k_split && !cur.c_flt
		|-> cpl_addr[`ASP_PA_MSB:0] == cur.req_addr[`ASP_PA_MSB:0])
		else $error("Split completion address differs from the intermediate address.");
	a_s2_size: assert property (s_walk_ok |=> cur.c_size == $past(s2_rsp_size))
		else $error("Completion size differs from stage 2 size.");
	a_insz_fault: assert property (s_take_big |=> cpl_valid && !cpl_r && !cpl_w)
		else $error("Oversized split request was not faulted.");
	a_ro_no_write: assert property ((s_walk_ok and (!s2_rsp_w && !cur.cfg[`ASP_F_FLUPD]))
		|=> !cur.c_w)
		else $error("Write granted on a read-only page.");
endmodule

// ==== testbench/asp_walk_model.sv ====
`timescale 1ns/1ps
module asp_walk_model
(
	input  wire logic               hclk,
	input  wire logic               hresetn,
	input  wire logic               s2_req_valid,
	input  wire asp_pkg::asp_addr_t s2_req_addr,
	input  wire logic               dirty_req_valid,
	input  wire logic [3:0]         dly,
	input  wire asp_pkg::asp_addr_t pg_pa,
	input  wire asp_pkg::asp_size_t pg_size,
	input  wire logic [3:0]         pg_perm,
	input  wire asp_pkg::asp_attr_t pg_attr,
	output logic                    s2_rsp_valid,
	output asp_pkg::asp_addr_t      s2_rsp_pa,
	output asp_pkg::asp_size_t      s2_rsp_size,
	output logic [3:0]              s2_rsp_perm,
	output asp_pkg::asp_attr_t      s2_rsp_attr,
	output logic                    dirty_ack,
	output asp_pkg::asp_addr_t      seen_addr,
	output logic [7:0]              dirty_cnt
);
	import asp_pkg::*;
	logic [3:0] wait_cnt;

	// Answers walks and dirty updates after a programmable delay; the answer
	// lines toggle when no answer is given so stale values never look valid.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			{s2_rsp_valid, dirty_ack, wait_cnt, dirty_cnt} <= '0;
			{s2_rsp_pa, s2_rsp_size, s2_rsp_perm, s2_rsp_attr, seen_addr} <= '0;
		end
		else
		begin
			s2_rsp_valid <= 1'b0;
			dirty_ack <= 1'b0;
			s2_rsp_pa <= ~s2_rsp_pa;
			s2_rsp_size <= ~s2_rsp_size;
			s2_rsp_perm <= ~s2_rsp_perm;
			s2_rsp_attr <= ~s2_rsp_attr;
			if ((s2_req_valid || dirty_req_valid) && !s2_rsp_valid && !dirty_ack)
			begin
				wait_cnt <= wait_cnt + 4'h1;
				if (wait_cnt >= dly)
				begin
					wait_cnt <= 4'h0;
					if (s2_req_valid)
					begin
						s2_rsp_valid <= 1'b1;
						s2_rsp_pa <= pg_pa;
						s2_rsp_size <= pg_size;
						s2_rsp_perm <= pg_perm;
						s2_rsp_attr <= pg_attr;
						seen_addr <= s2_req_addr;
					end
					else
					begin
						dirty_ack <= 1'b1;
						dirty_cnt <= dirty_cnt + 8'h01;
					end
				end
			end
			else
				wait_cnt <= 4'h0;
		end
	end
endmodule

// ==== testbench/tb_ats_stage_skip_permission_logic.sv ====
`timescale 1ns/1ps
`include "asp_defines.svh"
module tb_ats_stage_skip_permission_logic;
	import asp_pkg::*;
	logic        hclk, hresetn, hsel, hwrite, hready, cpl_ready, tr_valid, tr_pasid_present;
	logic        tr_nw, tr_exe, tr_priv, tx_valid, tx_pasid_present, tx_write, tx_exe, tx_priv;
	logic        hreadyout, hresp, tr_ready, s2_req_valid, s2_rsp_valid, dirty_req_valid;
	logic        dirty_ack, cpl_valid, cpl_handled, cpl_u, cpl_r, cpl_w, cpl_x, cpl_priv;
	logic        tx_attr_valid, tx_attr_write, tx_attr_inst, tx_attr_priv, xlat_s2_only;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [3:0]  dly, pg_perm, s2_perm;
	logic [7:0]  dirty_cnt;
	logic [5:0]  c_f;
	logic        s2_flt;
	asp_addr_t   tr_addr, s2_req_addr, s2_rsp_pa, dirty_req_addr, cpl_addr, pg_pa, seen_addr, c_a;
	asp_size_t   s2_rsp_size, cpl_size, pg_size, c_s;
	asp_attr_t   s2_rsp_attr, pg_attr;
	integer      mismatches, checked;

	assign hready = hreadyout;
	always #2.5 hclk = ~hclk;

	asp_skip_top #(.CNT_W(16)) uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready, .hreadyout, .hresp, .hrdata, .tr_valid, .tr_ready, .tr_addr,
		.tr_pasid_present, .tr_nw, .tr_exe, .tr_priv, .s2_req_valid, .s2_req_addr,
		.s2_rsp_valid, .s2_rsp_pa, .s2_rsp_size, .s2_rsp_r(s2_perm[0]), .s2_rsp_w(s2_perm[1]),
		.s2_rsp_x(s2_perm[2]), .s2_rsp_dmod(s2_perm[3]), .s2_rsp_fault(s2_flt), .s2_rsp_attr,
		.dirty_req_valid, .dirty_req_addr, .dirty_ack, .cpl_valid, .cpl_ready, .cpl_handled,
		.cpl_addr, .cpl_size, .cpl_u, .cpl_r, .cpl_w, .cpl_x, .cpl_priv, .tx_valid,
		.tx_pasid_present, .tx_write, .tx_exe, .tx_priv, .tx_attr_valid, .tx_attr_write,
		.tx_attr_inst, .tx_attr_priv, .xlat_s2_only);

	asp_walk_model walker (.hclk, .hresetn, .s2_req_valid, .s2_req_addr, .dirty_req_valid,
		.dly, .pg_pa, .pg_size, .pg_perm, .pg_attr, .s2_rsp_valid, .s2_rsp_pa, .s2_rsp_size,
		.s2_rsp_perm(s2_perm), .s2_rsp_attr, .dirty_ack, .seen_addr, .dirty_cnt);

	task automatic test_done;
		if (mismatches == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Cuts a hung handshake short.
	task automatic guard(input integer n);
		if (n >= 200)
		begin
			mismatches++;
			$display("MISMATCH at %0t: handshake timed out", $time);
			test_done;
		end
	endtask

	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] r);
		integer n;
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		n = 0;
		do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 200);
		guard(n);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		n = 0;
		do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 200);
		guard(n);
		r = hrdata;
	endtask

	task automatic xlat(input asp_addr_t a, input logic p, input logic nw, input logic ex,
		input logic pr);
		integer n;
		tr_addr <= a;
		tr_pasid_present <= p;
		tr_nw <= nw;
		tr_exe <= ex;
		tr_priv <= pr;
		tr_valid <= 1'b1;
		n = 0;
		do begin @(posedge hclk); n++; end while (tr_ready !== 1'b1 && n < 200);
		guard(n);
		tr_valid <= 1'b0;
		n = 0;
		do begin @(posedge hclk); n++; end while (cpl_valid !== 1'b1 && n < 200);
		guard(n);
		c_f = {cpl_handled, cpl_u, cpl_r, cpl_w, cpl_x, cpl_priv};
		c_a = cpl_addr;
		c_s = cpl_size;
		cpl_ready <= 1'b1;
		@(posedge hclk);
		cpl_ready <= 1'b0;
	endtask

	function automatic logic [31:0] cfgw(input logic [1:0] stg, input logic [1:0] mode,
		input logic [1:0] nps, input logic flag_upd, input asp_attr_t ov);
		return {8'h00, ov, 1'b0, ov != 8'h00, 1'b1, flag_upd, 1'b0, nps, 5'h01, mode, stg};
	endfunction

	function automatic asp_attr_t amin(input asp_attr_t a, input asp_attr_t b);
		return (b < a) ? b : a;
	endfunction

	task automatic t_regs;
		logic [31:0] r;
		ahb(1'b0, `ASP_REG_CFG, 32'h0, r);
		chk(r, `ASP_CFG_RST);
		ahb(1'b0, `ASP_REG_ASZ, 32'h0, r);
		chk(r, `ASP_ASZ_RST);
		ahb(1'b1, 32'h0000_0040, 32'hFFFF_FFFF, r);
		ahb(1'b0, 32'h0000_0040, 32'h0, r);
		chk(r, 32'h0);
	endtask

	task automatic t_ident;
		logic [31:0] r;
		asp_attr_t   ov;
		asp_addr_t   a;
		a = 64'h0000_1234_5678_9000;
		for (int i = 0; i < 2; i++)
		begin
			ov = i[0] ? 8'h12 : 8'h00;
			ahb(1'b1, `ASP_REG_CFG, cfgw(2'h1, 2'h1, 2'h1, 1'b0, ov), r);
			xlat(a, 1'b0, i[0], 1'b0, 1'b0);
			chk(c_f, 6'b101100);
			chk(c_a, {i[0] ? ov : `ASP_FIXED_ATTR, a[55:0]});
			chk(c_s, 6'h30);
		end
		ahb(1'b1, `ASP_REG_CFG, cfgw(2'h1, 2'h1, 2'h0, 1'b0, 8'h00), r);
		xlat(a, 1'b0, 1'b0, 1'b0, 1'b0);
		chk(c_f[5], 1'b0);
		ahb(1'b1, `ASP_REG_CFG, cfgw(2'h1, 2'h0, 2'h1, 1'b0, 8'h00), r);
		xlat(a, 1'b0, 1'b0, 1'b0, 1'b0);
		chk(c_f[5], 1'b0);
	endtask

	task automatic t_full;
		logic [31:0] r;
		ahb(1'b1, `ASP_REG_CFG, cfgw(2'h3, 2'h1, 2'h1, 1'b0, 8'h00), r);
		{pg_pa, pg_attr, pg_perm, pg_size, dly} = {64'h0000_00AB_CDEF_0000, 8'h40, 4'h3, 6'h15, 4'h3};
		xlat(64'h0000_0000_7777_0000, 1'b0, 1'b0, 1'b0, 1'b0);
		chk(c_f, 6'b101100);
		chk(c_a, {amin(`ASP_FIXED_ATTR, pg_attr), pg_pa[55:0]});
		chk(seen_addr, 64'h0000_0000_7777_0000);
		chk(xlat_s2_only, 1'b0);
	endtask

	task automatic t_split;
		logic [31:0] r;
		logic [7:0]  t;
		logic [7:0]  d0;
		asp_addr_t   imed;
		// Rows: nw, flag update, page modifier x w r, expected write, expected dirty mark.
		logic [7:0]  tbl [7] = '{8'h0E, 8'h8E, 8'h24, 8'hA4, 8'h67, 8'hE4, 8'h10};
		imed = 64'h0000_0012_3400_0000;
		for (int i = 0; i < 7; i++)
		begin
			t = tbl[i];
			ahb(1'b1, `ASP_REG_CFG, cfgw(2'h3, 2'h2, 2'h1, t[6], 8'h60), r);
			{pg_perm, pg_attr, pg_size, dly} = {t[5:2], i[0] ? 8'h90 : 8'h30, 6'h1E, i[0] ? 4'h5 : 4'h0};
			d0 = dirty_cnt;
			xlat(imed, 1'b0, t[7], 1'b0, 1'b0);
			chk(c_f, {2'b10, t[2], t[1], 2'b00});
			chk(dirty_cnt - d0, {7'h00, t[0]});
			chk(c_a, {8'h60, imed[55:0]});
			chk(c_s <= pg_size, 1'b1);
			chk(xlat_s2_only, 1'b1);
		end
		xlat(64'h0001_0000_0000_0000, 1'b0, 1'b0, 1'b0, 1'b0);
		chk(c_f[3:1], 3'b000);
		s2_flt <= 1'b1;
		xlat(imed, 1'b0, 1'b0, 1'b0, 1'b0);
		s2_flt <= 1'b0;
		chk(c_f, 6'b100000);
		xlat(imed, 1'b1, 1'b0, 1'b1, 1'b1);
		chk({c_f[5], c_f[1], c_f[0]}, 3'b001);
		xlat(imed, 1'b0, 1'b0, 1'b0, 1'b1);
		chk({c_f[1], c_f[0]}, 2'b00);
	endtask

	task automatic t_tx;
		logic [3:0] v;
		for (int i = 0; i < 16; i++)
		begin
			v = i[3:0];
			{tx_valid, tx_pasid_present, tx_write, tx_exe, tx_priv} <= {1'b1, v};
			@(posedge hclk);
			@(posedge hclk);
			chk({tx_attr_valid, tx_attr_write, tx_attr_inst, tx_attr_priv},
				{1'b1, v[2], v[3] & v[1] & !v[2], v[3] & v[0]});
		end
		tx_valid <= 1'b0;
	endtask

	initial
	begin
		{hclk, hresetn, hsel, hwrite, cpl_ready, tr_valid, tr_pasid_present, tr_nw} = '0;
		{tr_exe, tr_priv, tx_valid, tx_pasid_present, tx_write, tx_exe, tx_priv} = '0;
		{haddr, hwdata, htrans, hsize, tr_addr, dly, pg_perm, pg_pa, pg_size, pg_attr} = '0;
		s2_flt = 1'b0;
		mismatches = 0;
		checked = 0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_regs;
		t_ident;
		t_full;
		t_split;
		t_tx;
		test_done;
	end
endmodule
